/* File: design/ocld_pkg.sv */
// Purpose: Shared constants for the oscillator calibration, divider and
//          condition register slice.
// Assumes: 8-bit register address, 16-bit register data.
// Notes:   Every offset lives here, with the divider and calibration field positions and the non-zero reset values.
package ocld_pkg;
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   // Register offsets
   localparam logic [7:0] A_DIV_CTRL = 8'h3f;
   localparam logic [7:0] A_CAL_START = 8'h50;
   localparam logic [7:0] A_BIAS_WR = 8'h51;
   localparam logic [7:0] A_RF_CAL_WR = 8'h53;
   localparam logic [7:0] A_IF_CAL_WR = 8'h57;
   localparam logic [7:0] A_STARTUP = 8'h5a;
   localparam logic [7:0] A_BIAS_RD = 8'h5b;
   localparam logic [7:0] A_RF_CAL_RD = 8'h5c;
   localparam logic [7:0] A_IF_CAL_RD = 8'h5d;
   localparam logic [7:0] A_PROGRESS = 8'h5e;
   localparam logic [7:0] A_COND = 8'hc4;
   localparam logic [7:0] A_IRQ_EN = 8'hc5;
   localparam logic [7:0] A_DIV_RD = 8'hcf;
   // Field widths and positions
   localparam int BIAS_W = 5;
   localparam int CAL_W = 9;
   localparam int STARTUP_W = 12;
   localparam int IF_DIV_LSB = 4;
   localparam int LO_DIV_LSB = 0;
   localparam int CAL_BIAS_BIT = 0;
   localparam int CAL_RF_BIT = 1;
   localparam int CAL_IF_BIT = 2;
   // Reset values
   localparam int IF_STARTUP_US = 325;
   localparam logic [STARTUP_W-1:0] RST_STARTUP = STARTUP_W'(IF_STARTUP_US);
   localparam logic [7:0] RST_IRQ_EN = 8'h80;
   // Divider select codes
   typedef enum logic [2:0] {
      LO_OFF = 3'h0, LO_DIV1 = 3'h1, LO_DIV2 = 3'h2,
      LO_DIV4 = 3'h4, LO_DIV6 = 3'h5, LO_DIV8 = 3'h7
   } ocld_lo_div_e;
   typedef enum logic [1:0] {
      IF_DIV1 = 2'h0, IF_DIV4 = 2'h1, IF_DIV8 = 2'h2, IF_DIV16 = 2'h3
   } ocld_if_div_e;

   // LO code to ratio, zero meaning stopped
   function automatic logic [3:0] lo_ratio(input logic [2:0] code);
      case (code)
         LO_DIV1: lo_ratio = 4'h1;
         LO_DIV2: lo_ratio = 4'h2;
         LO_DIV4: lo_ratio = 4'h4;
         LO_DIV6: lo_ratio = 4'h6;
         LO_DIV8: lo_ratio = 4'h8;
         default: lo_ratio = 4'h0;
      endcase
   endfunction

   // IF output code to ratio
   function automatic logic [4:0] if_ratio(input logic [1:0] code);
      case (code)
         IF_DIV1: if_ratio = 5'h01;
         IF_DIV4: if_ratio = 5'h04;
         IF_DIV8: if_ratio = 5'h08;
         default: if_ratio = 5'h10;
      endcase
   endfunction
endpackage

/* File: design/ocld_cond_if.sv */
// Purpose: Carries condition state between the register file and the
//          condition latch unit.
// Assumes: Single clock domain.
// Notes:   rd_value is combinational in the latch unit.
`timescale 1ns/1ps
interface ocld_cond_if;
   logic [7:0] live;
   logic [7:0] en;
   logic rd_clr;
   logic loops_on;
   logic [7:0] flags;
   logic [7:0] rd_value;
   logic irq_n;
   modport regs (output live, en, rd_clr, loops_on, input flags, rd_value, irq_n);
   modport cond (input live, en, rd_clr, loops_on, output flags, rd_value, irq_n);
endinterface

/* File: design/ocld_cond.sv */
// Purpose: Condition bits: live view or edge latch, clear on read, interrupt.
// Assumes: live already synchronised to i_clk.
// Notes:   Bits 7..3 latch on rising edges, bits 2..0 on falling edges.
`timescale 1ns/1ps
module ocld_cond (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register side
   ocld_cond_if.cond c
);
   logic [7:0] lv;
   logic [7:0] prev;
   logic [7:0] evt;

   // Live state is void while the reference clock is gated
   assign lv = c.loops_on ? c.live : 8'h00;
   assign evt = {lv[7:3] & ~prev[7:3], ~lv[2:0] & prev[2:0]};

   // Edge detector history
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         prev <= 8'h00;
      else
         prev <= lv;
   end

   // Latch; a new event beats the read clear so none is lost
   always_ff @(posedge i_clk)
   begin
      if (i_rst || !c.loops_on)
         c.flags <= 8'h00;
      else if (c.rd_clr)
         c.flags <= evt & c.en;
      else
         c.flags <= (c.flags | evt) & c.en;
   end

   // Enabled bits show the latch, others the live level
   assign c.rd_value = (c.en & c.flags) | (~c.en & lv);
   assign c.irq_n = ~|c.flags;

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_rise7;
      c.loops_on && c.en[7] && $past(c.loops_on) && lv[7] && !prev[7];
   endsequence

   chk_latch_rise: assert property (s_rise7 |=> c.flags[7] && !c.irq_n)
      else $error("clock ready edge not latched");
   chk_read_clear: assert property (c.rd_clr && evt == 8'h00 |=> c.flags == 8'h00)
      else $error("condition read did not clear latch");
   chk_loops_off: assert property (!c.loops_on |=> c.flags == 8'h00 && c.irq_n)
      else $error("latch survived loops off");
   chk_live_view: assert property ((c.rd_value & ~c.en) == (c.live & ~c.en & {8{c.loops_on}}))
      else $error("disabled bit not live");
   chk_irq_hold: assert property ((c.flags & c.en) != 8'h00 && !c.rd_clr && c.loops_on
      |=> !c.irq_n)
      else $error("interrupt dropped while latched");
endmodule

/* File: design/ocld_regs.sv */
// Purpose: Register slice for oscillator start-up delay, calibration
//          read-back and progress, output dividers and condition flags.
// Assumes: Condition and comparator pins are asynchronous to i_clk;
//          loop enables and calibration done come from i_clk logic.
// Notes:   Read data is valid only in the cycle after the read strobe.
//
// What this block does
// - Start-up delay register holds microseconds, resets to 325, upper bits reserved.
// - Progress register bits 2,1,0 show IF, RF, bias calibration running.
// - Read-backs return their paired write registers; all reset to zero.
// - IF divider field bits 5:4 selects divide by 1, 4, 8, 16.
// - LO divider field bits 2:0 selects off, 1, 2, 4, 6, 8.
// - Disabled condition bit reads its live state at the read.
// - Enabled condition bit latches on its edge and asserts interrupt.
// - Reading the condition register clears every latched bit except one with a new edge in the read cycle.
// - With both loops off, reference clock stops and condition bits clear.
// - Bit 7 shows reference clock ready; latches on rising edge.
// - Bit 6 shows RF high comparator; latches on rising edge.
// - Bit 5 shows RF low comparator; latches on rising edge.
// - Bit 4 shows IF high comparator; latches on rising edge.
// - Bit 3 shows IF low comparator; latches on rising edge.
// - Bits 2,1,0 show both, IF, RF lock; latch on lock loss.
// - Writing bit 2 of start register begins IF calibration, sets progress.
`timescale 1ns/1ps
module ocld_regs (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [ocld_pkg::ADDR_W-1:0] i_addr,
   input wire logic [ocld_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [ocld_pkg::DATA_W-1:0] o_rdata,
   // Analogue status pins
   input wire logic i_clk_ready,
   input wire logic i_rf_cmp_hi,
   input wire logic i_rf_cmp_lo,
   input wire logic i_if_cmp_hi,
   input wire logic i_if_cmp_lo,
   input wire logic i_if_lock,
   input wire logic i_rf_lock,
   // Loop enables
   input wire logic i_rf_loop_en,
   input wire logic i_if_loop_en,
   // Calibration engine
   input wire logic [2:0] i_cal_done,
   output logic [2:0] o_cal_start,
   output logic [ocld_pkg::BIAS_W-1:0] o_bias_cal_setting,
   output logic [ocld_pkg::CAL_W-1:0] o_rf_cal_code,
   output logic [ocld_pkg::CAL_W-1:0] o_if_cal_code,
   output logic [ocld_pkg::STARTUP_W-1:0] o_if_osc_startup_delay,
   // Dividers and reference clock
   output logic [1:0] o_if_output_divider_select,
   output logic [2:0] o_local_osc_divider_select,
   output logic [4:0] o_if_div_ratio,
   output logic [3:0] o_lo_div_ratio,
   output logic o_ref_clk_run,
   // Interrupt
   output logic o_interrupt_request_low
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic wr_div;
   logic wr_start;
   logic rd_cond;
   logic [7:0] divider_control_reg;
   logic [7:0] irq_en;
   logic [2:0] cal_progress_reg;
   logic [6:0] pin_meta;
   logic [6:0] pin_sync;
   logic [ocld_pkg::DATA_W-1:0] next_rdata;

   ocld_cond_if cif ();

   ////////////////////////////////////////////////////////////////////////
   // Strobe decode
   assign wr_div = i_wr && i_addr == ocld_pkg::A_DIV_CTRL;
   assign wr_start = i_wr && i_addr == ocld_pkg::A_CAL_START;
   assign rd_cond = i_rd && i_addr == ocld_pkg::A_COND;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser, first stage feeds only the second
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pin_meta <= 7'h00;
         pin_sync <= 7'h00;
      end
      else
      begin
         pin_meta <= {i_clk_ready, i_rf_cmp_hi, i_rf_cmp_lo, i_if_cmp_hi,
                      i_if_cmp_lo, i_if_lock, i_rf_lock};
         pin_sync <= pin_meta;
      end
   end

   // Condition bit assembly, bit 2 combines both locks
   assign cif.live[7] = pin_sync[6];
   assign cif.live[6] = pin_sync[5];
   assign cif.live[5] = pin_sync[4];
   assign cif.live[4] = pin_sync[3];
   assign cif.live[3] = pin_sync[2];
   assign cif.live[2] = pin_sync[1] & pin_sync[0];
   assign cif.live[1:0] = pin_sync[1:0];
   assign cif.en = irq_en;
   assign cif.rd_clr = rd_cond;
   assign cif.loops_on = i_rf_loop_en | i_if_loop_en;

   ocld_cond u_cond (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .c(cif.cond)
   );

   ////////////////////////////////////////////////////////////////////////
   // Reference clock gate, off when neither loop runs
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_ref_clk_run <= 1'b0;
      else
         o_ref_clk_run <= cif.loops_on;
   end

   // Interrupt follows the latch, no extra delay
   assign o_interrupt_request_low = cif.irq_n;

   ////////////////////////////////////////////////////////////////////////
   // Start-up delay, only low bits kept; reserved bits dropped
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_if_osc_startup_delay <= ocld_pkg::RST_STARTUP;
      else if (i_wr && i_addr == ocld_pkg::A_STARTUP)
         o_if_osc_startup_delay <= i_wdata[ocld_pkg::STARTUP_W-1:0];
   end

   // Calibration settings; software may step codes up or down
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_bias_cal_setting <= '0;
         o_rf_cal_code <= '0;
         o_if_cal_code <= '0;
      end
      else if (i_wr)
      begin
         if (i_addr == ocld_pkg::A_BIAS_WR)
            o_bias_cal_setting <= i_wdata[ocld_pkg::BIAS_W-1:0];
         if (i_addr == ocld_pkg::A_RF_CAL_WR)
            o_rf_cal_code <= i_wdata[ocld_pkg::CAL_W-1:0];
         if (i_addr == ocld_pkg::A_IF_CAL_WR)
            o_if_cal_code <= i_wdata[ocld_pkg::CAL_W-1:0];
      end
   end

   // Interrupt enables, clock ready enabled after reset
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         irq_en <= ocld_pkg::RST_IRQ_EN;
      else if (i_wr && i_addr == ocld_pkg::A_IRQ_EN)
         irq_en <= i_wdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Start pulses to the calibration engine
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_cal_start <= 3'h0;
      else if (wr_start)
         o_cal_start <= i_wdata[2:0];
      else
         o_cal_start <= 3'h0;
   end

   // Progress flags; a start in the done cycle keeps the flag set
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         cal_progress_reg <= 3'h0;
      else
         cal_progress_reg <= (cal_progress_reg & ~i_cal_done) |
                             (wr_start ? i_wdata[2:0] : 3'h0);
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider control; whole byte kept so read-back is exact
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         divider_control_reg <= 8'h00;
      else if (wr_div)
         divider_control_reg <= i_wdata[7:0];
   end

   // Decoded ratios; illegal LO codes leave the divider stopped
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_if_div_ratio <= ocld_pkg::if_ratio(2'h0);
         o_lo_div_ratio <= ocld_pkg::lo_ratio(3'h0);
      end
      else if (wr_div)
      begin
         o_if_div_ratio <= ocld_pkg::if_ratio(i_wdata[ocld_pkg::IF_DIV_LSB +: 2]);
         o_lo_div_ratio <= ocld_pkg::lo_ratio(i_wdata[ocld_pkg::LO_DIV_LSB +: 3]);
      end
   end

   assign o_if_output_divider_select = divider_control_reg[ocld_pkg::IF_DIV_LSB +: 2];
   assign o_local_osc_divider_select = divider_control_reg[ocld_pkg::LO_DIV_LSB +: 3];

   ////////////////////////////////////////////////////////////////////////
   // Read mux; write-only and unmapped offsets read zero
   always_comb
   begin
      next_rdata = '0;
      case (i_addr)
         ocld_pkg::A_BIAS_RD:
            next_rdata = 16'(o_bias_cal_setting);
         ocld_pkg::A_RF_CAL_RD:
            next_rdata = 16'(o_rf_cal_code);
         ocld_pkg::A_IF_CAL_RD:
            next_rdata = 16'(o_if_cal_code);
         ocld_pkg::A_PROGRESS:
            next_rdata = 16'(cal_progress_reg);
         ocld_pkg::A_COND:
            next_rdata = 16'(cif.rd_value);
         ocld_pkg::A_DIV_RD:
            next_rdata = 16'(divider_control_reg);
         default:
            next_rdata = '0;
      endcase
   end

   // Read data stands one cycle only, zero otherwise
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_rdata <= '0;
      else if (i_rd)
         o_rdata <= next_rdata;
      else
         o_rdata <= '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_start_if;
      i_wr && i_addr == ocld_pkg::A_CAL_START && i_wdata[ocld_pkg::CAL_IF_BIT];
   endsequence

   sequence s_read_progress;
      i_rd && i_addr == ocld_pkg::A_PROGRESS;
   endsequence

   sequence s_write_bias;
      i_wr && i_addr == ocld_pkg::A_BIAS_WR;
   endsequence

   sequence s_read_bias;
      i_rd && i_addr == ocld_pkg::A_BIAS_RD;
   endsequence

   sequence s_write_startup;
      i_wr && i_addr == ocld_pkg::A_STARTUP;
   endsequence

   sequence s_done_only;
      !wr_start && i_cal_done != 3'h0;
   endsequence

   property p_start_seen;
      s_start_if ##1 s_read_progress |=> o_rdata[ocld_pkg::CAL_IF_BIT];
   endproperty

   property p_bias_round;
      s_write_bias ##1 s_read_bias |=>
         o_rdata == 16'($past(i_wdata[ocld_pkg::BIAS_W-1:0], 2));
   endproperty

   chk_startup_reset: assert property ($past(i_rst) && !$past(i_wr) |->
      o_if_osc_startup_delay == ocld_pkg::RST_STARTUP)
      else $error("start-up delay not at reset value");
   chk_start_progress: assert property (p_start_seen)
      else $error("IF calibration start not shown in progress");
   chk_progress_idle: assert property (cal_progress_reg == 3'h0 ##0 s_read_progress
      |=> o_rdata == 16'h0000)
      else $error("idle progress read not zero");
   chk_bias_readback: assert property (p_bias_round)
      else $error("bias read-back mismatch");
   chk_if_divider: assert property (wr_div |=>
      o_if_div_ratio == ocld_pkg::if_ratio(o_if_output_divider_select))
      else $error("IF divider ratio wrong");
   chk_lo_divider: assert property (wr_div && i_wdata[2:0] == 3'h5 |=>
      o_lo_div_ratio == 4'h6)
      else $error("LO divide by six not selected");
   chk_cond_sample: assert property (rd_cond |=> o_rdata[7:0] == $past(cif.rd_value))
      else $error("condition read not sampled at strobe");
   chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data outside its cycle");
   chk_clk_gate: assert property (!i_rf_loop_en && !i_if_loop_en |=>
      !o_ref_clk_run && o_interrupt_request_low)
      else $error("reference clock not gated");

   // Write side: each setting shows at the edge after its strobe
   chk_startup_write: assert property (s_write_startup |=>
      o_if_osc_startup_delay == $past(i_wdata[ocld_pkg::STARTUP_W-1:0]))
      else $error("start-up delay write lost");
   chk_div_select: assert property (wr_div |=>
      o_local_osc_divider_select == $past(i_wdata[2:0]) &&
      o_if_output_divider_select == $past(i_wdata[5:4]))
      else $error("divider select not taken");
   chk_lo_div8: assert property (wr_div && i_wdata[2:0] == 3'h7 |=>
      o_lo_div_ratio == 4'h8)
      else $error("LO divide by eight not selected");
   chk_if_div16: assert property (wr_div && i_wdata[5:4] == 2'h3 |=>
      o_if_div_ratio == 5'h10)
      else $error("IF divide by sixteen not selected");

   // Calibration handshake: one-cycle start, done drops its flag; reference clock follows the loops
   chk_cal_pulse: assert property (wr_start |=> o_cal_start == $past(i_wdata[2:0]))
      else $error("start pulse does not copy the write");
   chk_cal_quiet: assert property (!wr_start |=> o_cal_start == 3'h0)
      else $error("start pulse longer than one cycle");
   chk_done_clear: assert property (s_done_only |=>
      (cal_progress_reg & $past(i_cal_done)) == 3'h0)
      else $error("finished calibration still shown busy");
   chk_ref_follow: assert property (cif.loops_on |=> o_ref_clk_run)
      else $error("reference clock not running with a loop on");
endmodule

/* File: tb/test_ocld_regs.sv */
// Purpose: Self-checking bench for the oscillator calibration, divider and condition registers.
// Assumes: Reads answer in the cycle after the strobe; status pins settle in 3 cycles.
// Notes:   Expected read data queue up at the strobe and are popped by a monitor.
`timescale 1ns/1ps
module test_ocld_regs;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] o_rdata;
   logic i_clk_ready = 1'b0, i_rf_cmp_hi = 1'b0, i_rf_cmp_lo = 1'b0, i_if_cmp_hi = 1'b0;
   logic i_if_cmp_lo = 1'b0, i_if_lock = 1'b0, i_rf_lock = 1'b0;
   logic i_rf_loop_en = 1'b0, i_if_loop_en = 1'b0;
   logic [2:0] i_cal_done = 3'h0;
   logic [2:0] o_cal_start;
   logic [4:0] o_bias_cal_setting;
   logic [8:0] o_rf_cal_code, o_if_cal_code;
   logic [11:0] o_if_osc_startup_delay;
   logic [1:0] o_if_output_divider_select;
   logic [2:0] o_local_osc_divider_select;
   logic [4:0] o_if_div_ratio;
   logic [3:0] o_lo_div_ratio;
   logic o_ref_clk_run, o_interrupt_request_low;
   int err_total = 0;
   int comparisons = 0;
   int seed = 32'h8983;
   logic [15:0] exp_q [$];
   logic rd_seen = 1'b0;
   logic [15:0] val;
   logic [3:0] lo_tab [8] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h4, 4'h6, 4'h0, 4'h8};
   logic [4:0] if_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h10};

   ocld_regs u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_clk_ready(i_clk_ready), .i_rf_cmp_hi(i_rf_cmp_hi),
      .i_rf_cmp_lo(i_rf_cmp_lo), .i_if_cmp_hi(i_if_cmp_hi), .i_if_cmp_lo(i_if_cmp_lo),
      .i_if_lock(i_if_lock), .i_rf_lock(i_rf_lock), .i_rf_loop_en(i_rf_loop_en),
      .i_if_loop_en(i_if_loop_en), .i_cal_done(i_cal_done), .o_cal_start(o_cal_start),
      .o_bias_cal_setting(o_bias_cal_setting), .o_rf_cal_code(o_rf_cal_code),
      .o_if_cal_code(o_if_cal_code), .o_if_osc_startup_delay(o_if_osc_startup_delay),
      .o_if_output_divider_select(o_if_output_divider_select),
      .o_local_osc_divider_select(o_local_osc_divider_select),
      .o_if_div_ratio(o_if_div_ratio), .o_lo_div_ratio(o_lo_div_ratio),
      .o_ref_clk_run(o_ref_clk_run), .o_interrupt_request_low(o_interrupt_request_low)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   always #20 i_clk = ~i_clk;

   // Single comparison point, counts every compare
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Verdict in one place
   task automatic close_out();
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One-cycle write strobe, idle cycle left before the next request
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // Write then read with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [7:0] ra,
                        input logic [15:0] e);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      i_addr <= ra;
      exp_q.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask

   // Read strobe; the expected word waits in the queue for the monitor
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask

   // Pins cross two flops plus an edge stage, so give them a margin
   task automatic settle();
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: data stand only in the cycle after the strobe, so sample it there
   always @(posedge i_clk)
   begin
      if (rd_seen)
      begin
         if (exp_q.size() == 0)
            check(o_rdata, 16'hffff);
         else
            check(o_rdata, exp_q.pop_front());
      end
      rd_seen <= i_rd;
   end

   // Watchdog at 20000 cycles, far beyond the couple of hundred cycles the sequence needs
   initial
   begin
      #(40 * 20000);
      err_total++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      // Reset state of outputs and read-backs
      check(16'(o_if_osc_startup_delay), 16'h0145);
      check(16'(o_if_div_ratio), 16'h0001);
      check(16'(o_lo_div_ratio), 16'h0000);
      check(16'(o_interrupt_request_low), 16'h0001);
      rd(ocld_pkg::A_BIAS_RD, 16'h0000);
      rd(ocld_pkg::A_RF_CAL_RD, 16'h0000);
      rd(ocld_pkg::A_IF_CAL_RD, 16'h0000);
      rd(ocld_pkg::A_DIV_RD, 16'h0000);
      rd(ocld_pkg::A_PROGRESS, 16'h0000);
      rd(ocld_pkg::A_STARTUP, 16'h0000);
      rd(8'h00, 16'h0000);
      // Random write data, reserved bits must not reach the outputs
      val = 16'($random(seed));
      wr(ocld_pkg::A_STARTUP, val);
      @(negedge i_clk);
      check(16'(o_if_osc_startup_delay), {4'h0, val[11:0]});
      val = 16'($random(seed));
      wr_rd(ocld_pkg::A_BIAS_WR, val, ocld_pkg::A_BIAS_RD, {11'h000, val[4:0]});
      check(16'(o_bias_cal_setting), {11'h000, val[4:0]});
      val = 16'($random(seed));
      wr(ocld_pkg::A_RF_CAL_WR, val);
      rd(ocld_pkg::A_RF_CAL_RD, {7'h00, val[8:0]});
      check(16'(o_rf_cal_code), {7'h00, val[8:0]});
      val = 16'($random(seed));
      wr(ocld_pkg::A_IF_CAL_WR, val);
      rd(ocld_pkg::A_IF_CAL_RD, {7'h00, val[8:0]});
      check(16'(o_if_cal_code), {7'h00, val[8:0]});
      // Every legal divider code; codes 3 and 6 are never written by software
      for (int i = 0; i < 8; i++)
      begin
         if (i == 3 || i == 6)
            continue;
         val = {10'h000, 2'(i), 1'b0, 3'(i)};
         wr(ocld_pkg::A_DIV_CTRL, val);
         @(negedge i_clk);
         check(16'(o_lo_div_ratio), 16'(lo_tab[i]));
         check(16'(o_if_div_ratio), 16'(if_tab[i % 4]));
         check(16'(o_local_osc_divider_select), 16'(i));
         check(16'(o_if_output_divider_select), 16'(i % 4));
         rd(ocld_pkg::A_DIV_RD, val);
      end
      // Calibration starts, then finish one by one
      wr(ocld_pkg::A_CAL_START, 16'h0007);
      @(negedge i_clk);
      check(16'(o_cal_start), 16'h0007);
      rd(ocld_pkg::A_PROGRESS, 16'h0007);
      for (int b = 0; b < 3; b++)
      begin
         @(posedge i_clk);
         i_cal_done <= 3'(1 << b);
         @(posedge i_clk);
         i_cal_done <= 3'h0;
         rd(ocld_pkg::A_PROGRESS, 16'(3'(3'h7 << (b + 1))));
      end
      // Start and progress read back to back, then let it finish before enables
      wr_rd(ocld_pkg::A_CAL_START, 16'h0004, ocld_pkg::A_PROGRESS, 16'h0004);
      @(posedge i_clk);
      i_cal_done <= 3'h4;
      @(posedge i_clk);
      i_cal_done <= 3'h0;
      rd(ocld_pkg::A_PROGRESS, 16'h0000);
      // Live view with all enables clear
      @(posedge i_clk);
      i_rf_loop_en <= 1'b1;
      i_clk_ready <= 1'b1;
      i_rf_cmp_hi <= 1'b1;
      i_if_lock <= 1'b1;
      i_rf_lock <= 1'b1;
      wr(ocld_pkg::A_IRQ_EN, 16'h0000);
      settle();
      check(16'(o_ref_clk_run), 16'h0001);
      rd(ocld_pkg::A_COND, 16'h00c7);
      rd(ocld_pkg::A_IRQ_EN, 16'h0000);
      // Latched view: rising edges on 5..3, falls on 7 and 6 ignored, lock loss on 2 and 0
      wr(ocld_pkg::A_IRQ_EN, 16'h00ff);
      settle();
      check(16'(o_interrupt_request_low), 16'h0001);
      @(posedge i_clk);
      i_rf_cmp_lo <= 1'b1;
      i_if_cmp_hi <= 1'b1;
      i_if_cmp_lo <= 1'b1;
      i_rf_lock <= 1'b0;
      i_clk_ready <= 1'b0;
      i_rf_cmp_hi <= 1'b0;
      settle();
      check(16'(o_interrupt_request_low), 16'h0000);
      rd(ocld_pkg::A_COND, 16'h003d);
      @(negedge i_clk);
      check(16'(o_interrupt_request_low), 16'h0001);
      rd(ocld_pkg::A_COND, 16'h0000);
      // Clock ready rises and latches, then both loops off clear it
      @(posedge i_clk);
      i_clk_ready <= 1'b1;
      settle();
      check(16'(o_interrupt_request_low), 16'h0000);
      @(posedge i_clk);
      i_rf_loop_en <= 1'b0;
      settle();
      check(16'(o_ref_clk_run), 16'h0000);
      check(16'(o_interrupt_request_low), 16'h0001);
      wr(ocld_pkg::A_IRQ_EN, 16'h0000);
      rd(ocld_pkg::A_COND, 16'h0000);
      repeat (4) @(posedge i_clk);
      close_out();
   end
endmodule
